// *** core_cfg_pkg.sv ***
// constants shared by the core status, option and configuration logic
package core_cfg_pkg;

    localparam int          DATA_ADDR_W       = 5;
    localparam logic [4:0]  ALU_FLAGS_ADDR    = 5'h03;

    // status bit positions
    localparam int          ST_CARRY          = 0;
    localparam int          ST_NIBBLE_CARRY   = 1;
    localparam int          ST_ZERO           = 2;
    localparam int          ST_POWERDOWN      = 3;
    localparam int          ST_TIMEOUT        = 4;
    localparam int          ST_PAGE_LOW       = 5;
    localparam int          ST_PAGE_HIGH      = 6;
    localparam int          ST_SPARE_PAGE     = 7;
    localparam logic [7:0]  STATUS_RESET      = 8'h18;

    // option register
    localparam int          OPTION_W          = 6;
    localparam logic [5:0]  OPTION_RESET      = 6'h3f;
    localparam int          OPT_SOURCE        = 5;
    localparam int          OPT_EDGE          = 4;
    localparam int          OPT_ASSIGN        = 3;
    localparam int          OPT_RATE_HI       = 2;
    localparam int          OPT_RATE_LO       = 0;

    // configuration word
    localparam int          CONFIG_W          = 12;
    localparam int          CFG_OSC_HI        = 1;
    localparam int          CFG_OSC_LO        = 0;
    localparam int          CFG_WATCHDOG_EN   = 2;
    localparam int          CFG_PROTECT_HI    = 11;
    localparam int          CFG_PROTECT_LO    = 3;
    localparam int          CFG_PROTECT_W     = 9;
    localparam logic [11:0] CONFIG_RESET      = 12'hfff;

    localparam logic [1:0]  OSC_LOW_POWER     = 2'b00;
    localparam logic [1:0]  OSC_STANDARD      = 2'b01;
    localparam logic [1:0]  OSC_HIGH_SPEED    = 2'b10;
    localparam logic [1:0]  OSC_RC            = 2'b11;

    typedef enum logic [1:0] {
        osc_low_power_crystal,
        osc_standard_crystal,
        osc_high_speed_crystal,
        osc_rc
    } osc_kind_t;

endpackage

// *** config_decode_if.sv ***
// carrier between the top and the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
interface config_decode_if;
    import core_cfg_pkg::*;
    logic [CONFIG_W-1:0] config_word;
    osc_kind_t           osc_kind;
    logic                watchdog_on;
    logic                protect_on;

    modport decoder (input config_word, output osc_kind, output watchdog_on, output protect_on);
    modport user    (output config_word, input osc_kind, input watchdog_on, input protect_on);
endinterface
`default_nettype wire

// *** config_word_decode.sv ***
// combinational decode of the non-volatile configuration word
`timescale 1ns/1ps
`default_nettype none
module config_word_decode #(
    parameter bit NEWER_VARIANT = 1'b1
) (
    config_decode_if.decoder cfg
);
    import core_cfg_pkg::*;

    wire [1:0] osc_bits = cfg.config_word[CFG_OSC_HI:CFG_OSC_LO];
    wire [CFG_PROTECT_W-1:0] protect_bits = cfg.config_word[CFG_PROTECT_HI:CFG_PROTECT_LO];
    // older parts carry one protect bit in the lowest protect position
    wire protect_new = ~&protect_bits;
    wire protect_old = ~protect_bits[0];

    always_comb begin
        case (osc_bits)
            OSC_LOW_POWER:  cfg.osc_kind = osc_low_power_crystal;
            OSC_STANDARD:   cfg.osc_kind = osc_standard_crystal;
            OSC_HIGH_SPEED: cfg.osc_kind = osc_high_speed_crystal;
            OSC_RC:         cfg.osc_kind = osc_rc;
            default:        cfg.osc_kind = osc_rc;
        endcase
    end

    assign cfg.watchdog_on = cfg.config_word[CFG_WATCHDOG_EN];
    assign cfg.protect_on  = NEWER_VARIANT ? protect_new : protect_old;
endmodule // config_word_decode
`default_nettype wire

// *** core_status_option_config.sv ***
// status register, option register and configuration decode of the core
// Operation
// - status register sits at data address 03h
// - flag-updating instructions override written zero/carries
// - time-out and power-down flags ignore writes
// - clear-file clears page bits, sets zero
// - bits 6-5 preselect program page
// - option is six-bit write-only prescaler control
// - option-load instruction copies working register in
// - reset sets option bits 5-0, 7-6 zero
// - option bit 5 selects timer source
// - option bit 4 selects external edge
// - option bit 3 assigns shared prescaler (code gates only the watchdog division; timer division stays rate plus one)
// - rate field sets timer/watchdog division
// - config bits 1-0 select oscillator type
// - config bit 2 enables watchdog
// - newer parts: bits 11-3 code protection
// - older parts: single code protection bit
`timescale 1ns/1ps
`default_nettype none
module core_status_option_config #(
    parameter bit LARGE_PROGRAM  = 1'b1,
    parameter bit NEWER_VARIANT  = 1'b1
) (
    input  wire logic                                   clk_sys_in,
    input  wire logic                                   reset_in,
    // file register access from the execution logic
    input  wire logic [core_cfg_pkg::DATA_ADDR_W-1:0]   file_addr_in,
    input  wire logic                                   file_wr_in,
    input  wire logic [7:0]                             file_wr_data_in,
    input  wire logic                                   file_rd_in,
    input  wire logic                                   clear_file_instr_in,
    // flag results of the executing instruction
    input  wire logic                                   zero_update_in,
    input  wire logic                                   nibble_carry_update_in,
    input  wire logic                                   carry_update_in,
    input  wire logic                                   zero_result_in,
    input  wire logic                                   nibble_carry_result_in,
    input  wire logic                                   carry_result_in,
    // reset-status events
    input  wire logic                                   power_up_in,
    input  wire logic                                   watchdog_clear_instr_in,
    input  wire logic                                   sleep_instr_in,
    input  wire logic                                   watchdog_timeout_in,
    // option load
    input  wire logic                                   option_load_in,
    input  wire logic [7:0]                             work_reg_in,
    // configuration word
    input  wire logic [core_cfg_pkg::CONFIG_W-1:0]      config_word_in,
    // results
    output logic [7:0]                                  file_rd_data_out,
    output logic                                        file_rd_hit_out,
    output logic [7:0]                                  alu_and_reset_flags_out,
    output logic [1:0]                                  page_select_out,
    output logic [7:0]                                  timer_prescaler_setup_out,
    output logic                                        timer_source_select_out,
    output logic                                        timer_edge_select_out,
    output logic                                        prescaler_assign_out,
    output logic [2:0]                                  prescaler_rate_out,
    output logic [3:0]                                  timer_div_log2_out,
    output logic [3:0]                                  watchdog_div_log2_out,
    output logic [1:0]                                  oscillator_type_select_out,
    output logic                                        watchdog_enable_bit_out,
    output logic                                        code_protect_on_out
);
    import core_cfg_pkg::*;

    logic [7:0]          status_q;
    logic [7:0]          status_d;
    logic [OPTION_W-1:0] option_q;
    logic [OPTION_W-1:0] option_d;
    logic [CONFIG_W-1:0] config_q;

    config_decode_if cfg_bus ();

    config_word_decode #(
        .NEWER_VARIANT (NEWER_VARIANT)
    ) u_decode (
        .cfg (cfg_bus.decoder)
    );

    assign cfg_bus.config_word = config_q;

    // address decode
    wire status_hit   = (file_addr_in == ALU_FLAGS_ADDR);
    wire status_write = file_wr_in & status_hit;
    wire clear_write  = status_write & clear_file_instr_in;

    // written value with clear-file forcing page bits low and zero high
    wire [7:0] write_value = clear_write ? {3'b000, status_q[ST_TIMEOUT],
                                            status_q[ST_POWERDOWN], 1'b1,
                                            status_q[ST_NIBBLE_CARRY],
                                            status_q[ST_CARRY]}
                                         : file_wr_data_in;

    wire [7:0] after_write = status_write ? write_value : status_q;

    // flag results win over the written bits
    wire zero_next  = zero_update_in ? zero_result_in : after_write[ST_ZERO];
    wire nib_next   = nibble_carry_update_in ? nibble_carry_result_in
                                             : after_write[ST_NIBBLE_CARRY];
    wire carry_next = carry_update_in ? carry_result_in : after_write[ST_CARRY];

    // the set events win over the clearing event if they coincide
    wire timeout_set   = power_up_in | watchdog_clear_instr_in | sleep_instr_in;
    wire timeout_next  = timeout_set ? 1'b1
                       : (watchdog_timeout_in ? 1'b0 : status_q[ST_TIMEOUT]);
    wire powerdown_set = power_up_in | watchdog_clear_instr_in;
    wire powerdown_next = powerdown_set ? 1'b1
                        : (sleep_instr_in ? 1'b0 : status_q[ST_POWERDOWN]);

    assign status_d = {after_write[ST_SPARE_PAGE],
                       after_write[ST_PAGE_HIGH],
                       after_write[ST_PAGE_LOW],
                       timeout_next,
                       powerdown_next,
                       zero_next,
                       nib_next,
                       carry_next};

    // option has no path other than the option-load instruction
    assign option_d = option_load_in ? work_reg_in[OPTION_W-1:0] : option_q;

    wire [2:0] rate_next = option_d[OPT_RATE_HI:OPT_RATE_LO];
    // timer division is the rate field plus one; watchdog division is the rate field while option bit 3 is set, else zero
    wire [3:0] timer_log2_next = {1'b0, rate_next} + 4'h1;
    wire [3:0] wdt_log2_next   = option_d[OPT_ASSIGN] ? {1'b0, rate_next} : 4'h0;

    wire [1:0] page_next = LARGE_PROGRAM ? status_d[ST_PAGE_HIGH:ST_PAGE_LOW]
                                         : 2'b00;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            status_q <= STATUS_RESET;
            option_q <= OPTION_RESET;
            config_q <= CONFIG_RESET;
        end else begin
            status_q <= status_d;
            option_q <= option_d;
            config_q <= config_word_in;
        end
    end

    // read port: status only; other addresses answer zero with no hit
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            file_rd_data_out <= 8'h00;
            file_rd_hit_out  <= 1'b0;
        end else begin
            file_rd_data_out <= (file_rd_in & status_hit) ? status_q : 8'h00;
            file_rd_hit_out  <= file_rd_in & status_hit;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            alu_and_reset_flags_out   <= STATUS_RESET;
            page_select_out           <= 2'b00;
            timer_prescaler_setup_out <= {2'b00, OPTION_RESET};
            timer_source_select_out   <= OPTION_RESET[OPT_SOURCE];
            timer_edge_select_out     <= OPTION_RESET[OPT_EDGE];
            prescaler_assign_out      <= OPTION_RESET[OPT_ASSIGN];
            prescaler_rate_out        <= OPTION_RESET[OPT_RATE_HI:OPT_RATE_LO];
            timer_div_log2_out        <= {1'b0, OPTION_RESET[OPT_RATE_HI:OPT_RATE_LO]} + 4'h1;
            watchdog_div_log2_out     <= {1'b0, OPTION_RESET[OPT_RATE_HI:OPT_RATE_LO]};
        end else begin
            alu_and_reset_flags_out   <= status_d;
            page_select_out           <= page_next;
            timer_prescaler_setup_out <= {2'b00, option_d};
            timer_source_select_out   <= option_d[OPT_SOURCE];
            timer_edge_select_out     <= option_d[OPT_EDGE];
            prescaler_assign_out      <= option_d[OPT_ASSIGN];
            prescaler_rate_out        <= rate_next;
            timer_div_log2_out        <= timer_log2_next;
            watchdog_div_log2_out     <= wdt_log2_next;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            oscillator_type_select_out <= OSC_RC;
            watchdog_enable_bit_out    <= 1'b1;
            code_protect_on_out        <= 1'b0;
        end else begin
            oscillator_type_select_out <= cfg_bus.osc_kind;
            watchdog_enable_bit_out    <= cfg_bus.watchdog_on;
            code_protect_on_out        <= cfg_bus.protect_on;
        end
    end

endmodule // core_status_option_config
`default_nettype wire

// *** status_props.sv ***
// concurrent checks on the ports of the core status, option and configuration block
`timescale 1ns/1ps
`default_nettype none
module status_props
    import core_cfg_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic [4:0]  file_addr_in,
    input  wire logic        file_wr_in,
    input  wire logic        file_rd_in,
    input  wire logic        clear_file_instr_in,
    input  wire logic        zero_update_in,
    input  wire logic        carry_update_in,
    input  wire logic        zero_result_in,
    input  wire logic        carry_result_in,
    input  wire logic        power_up_in,
    input  wire logic        watchdog_clear_instr_in,
    input  wire logic        sleep_instr_in,
    input  wire logic        watchdog_timeout_in,
    input  wire logic        option_load_in,
    input  wire logic [7:0]  work_reg_in,
    input  wire logic [11:0] config_word_in,
    input  wire logic [7:0]  file_rd_data_out,
    input  wire logic        file_rd_hit_out,
    input  wire logic [7:0]  alu_and_reset_flags_out,
    input  wire logic [1:0]  page_select_out,
    input  wire logic [7:0]  timer_prescaler_setup_out,
    input  wire logic [1:0]  oscillator_type_select_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    logic [7:0] st;
    logic       ev_set;
    logic       st_rd;
    assign st     = alu_and_reset_flags_out;
    assign ev_set = power_up_in | watchdog_clear_instr_in;
    assign st_rd  = file_rd_in && file_addr_in == ALU_FLAGS_ADDR;

    rd_hit_a: assert property (st_rd |=> file_rd_hit_out && file_rd_data_out == $past(st))
        else $error("status read not answered");
    rd_miss_a: assert property (!st_rd |=> !file_rd_hit_out && file_rd_data_out == 8'h00)
        else $error("read answered off the status address");
    flags_kept_a: assert property (!(ev_set | sleep_instr_in | watchdog_timeout_in)
        |=> st[4:3] == $past(st[4:3])) else $error("timeout or powerdown flag moved");
    zero_set_a: assert property (zero_update_in |=> st[ST_ZERO] == $past(zero_result_in))
        else $error("zero flag not taken from result");
    carry_set_a: assert property (carry_update_in |=> st[ST_CARRY] == $past(carry_result_in))
        else $error("carry flag not taken from result");
    clear_file_a: assert property (file_wr_in && clear_file_instr_in && !zero_update_in
        && file_addr_in == ALU_FLAGS_ADDR |=> st[7:5] == 3'b000 && st[ST_ZERO])
        else $error("clear-file result wrong");
    sleep_flags_a: assert property (sleep_instr_in && !ev_set |=> st[4:3] == 2'b10)
        else $error("sleep flags wrong");
    timeout_clr_a: assert property (watchdog_timeout_in && !ev_set && !sleep_instr_in
        |=> !st[ST_TIMEOUT]) else $error("timeout flag not cleared");
    opt_load_a: assert property (option_load_in |=> timer_prescaler_setup_out ==
        {2'b00, $past(work_reg_in[5:0])}) else $error("option load wrong");
    opt_hold_a: assert property (!option_load_in |=> $stable(timer_prescaler_setup_out))
        else $error("option changed without load");
    page_sel_a: assert property (page_select_out == st[6:5])
        else $error("page select differs from status");
    osc_sel_a: assert property ($stable(config_word_in)[*3]
        |-> oscillator_type_select_out == config_word_in[1:0]) else $error("osc select wrong");
endmodule // status_props
`default_nettype wire

// *** core_exec_model.sv ***
// behavioural execution logic that issues one core operation per cycle
`timescale 1ns/1ps
`default_nettype none
module core_exec_model (
    input  wire logic  clk_sys_in,
    output logic [4:0] addr_out,
    output logic       wr_out,
    output logic       rd_out,
    output logic       clr_out,
    output logic [7:0] wd_out,
    output logic [2:0] upd_out,
    output logic [2:0] res_out,
    output logic [3:0] ev_out,
    output logic       ld_out,
    output logic [7:0] work_out
);
    initial {addr_out, wr_out, rd_out, clr_out, wd_out, upd_out, res_out, ev_out, ld_out, work_out} = '0;
    // operands change just after the edge and stand for the whole cycle
    // writes that also carry flag updates stand for instructions beyond bit set, clear and move
    task automatic op(input logic [4:0] a, input logic w, r, c, input logic [7:0] d,
                      input logic [2:0] u, s, input logic [3:0] e, input logic l,
                      input logic [7:0] k);
        @(posedge clk_sys_in);
        #1;
        {addr_out, wr_out, rd_out, clr_out, wd_out} = {a, w, r, c, d};
        {upd_out, res_out, ev_out, ld_out, work_out} = {u, s, e, l, k};
    endtask
endmodule // core_exec_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the core status, option and configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import core_cfg_pkg::*;
    logic        clk_sys_in, reset_in, wr, rd, clr, ld, w, c, rdh, src, edg, asg, wen, prot;
    logic [11:0] cfg;
    logic [4:0]  addr, a;
    logic [7:0]  wd, work, d, k, st, rdd, setup, flg;
    logic [2:0]  upd, res, u, s, rate;
    logic [3:0]  ev, e, tdiv, wdiv;
    logic [1:0]  osc, pg;
    logic [7:0]  exp_q[$];
    int          seed = 65275, mismatches = 0, n_compared = 0, cycles = 0;

    core_exec_model i_core_exec_model (.clk_sys_in(clk_sys_in), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .clr_out(clr), .wd_out(wd), .upd_out(upd), .res_out(res), .ev_out(ev),
        .ld_out(ld), .work_out(work));
    core_status_option_config i_core_status_option_config (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .file_addr_in(addr), .file_wr_in(wr), .file_wr_data_in(wd),
        .file_rd_in(rd), .clear_file_instr_in(clr), .zero_update_in(upd[2]),
        .nibble_carry_update_in(upd[1]), .carry_update_in(upd[0]), .zero_result_in(res[2]),
        .nibble_carry_result_in(res[1]), .carry_result_in(res[0]), .power_up_in(ev[3]),
        .watchdog_clear_instr_in(ev[2]), .sleep_instr_in(ev[1]), .watchdog_timeout_in(ev[0]),
        .option_load_in(ld), .work_reg_in(work), .config_word_in(cfg), .file_rd_data_out(rdd),
        .file_rd_hit_out(rdh), .alu_and_reset_flags_out(flg), .page_select_out(pg),
        .timer_prescaler_setup_out(setup), .timer_source_select_out(src),
        .timer_edge_select_out(edg), .prescaler_assign_out(asg), .prescaler_rate_out(rate),
        .timer_div_log2_out(tdiv), .watchdog_div_log2_out(wdiv),
        .oscillator_type_select_out(osc), .watchdog_enable_bit_out(wen), .code_protect_on_out(prot));

    always #20 clk_sys_in = ~clk_sys_in;

    task automatic chk(input string nm, input logic [11:0] ex, got);
        n_compared++;
        if (got !== ex) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // e is {power-up, watchdog clear, sleep, watchdog timeout}; a set event beats a clear
    function automatic logic [7:0] nxt(logic [7:0] o, logic hit, c, logic [7:0] d,
                                       logic [2:0] u, s, logic [3:0] e);
        logic [7:0] n;
        n = hit ? {d[7:5], o[4:3], d[2:0]} : o;
        // clear-file keeps the old carries, whatever the written data held
        if (hit && c) n = {3'b000, o[4:3], 1'b1, o[1:0]};
        for (int i = 0; i < 3; i++) if (u[i]) n[i] = s[i];
        if (|e[3:1]) n[4] = 1'b1; else if (e[0]) n[4] = 1'b0;
        if (|e[3:2]) n[3] = 1'b1; else if (e[1]) n[3] = 1'b0;
        return n;
    endfunction

    always @(negedge clk_sys_in) begin
        if (rdh === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 12'h000, 12'hfff);
            else chk("status read", 12'(exp_q.pop_front()), {4'h0, rdd});
        end
    end

    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        {clk_sys_in, reset_in, cfg, st} = {2'b01, 12'hfff, STATUS_RESET};
        repeat (4) @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        chk("option reset", 12'h03f, {4'h0, setup});
        chk("divider reset", 12'h087, {4'h0, tdiv, wdiv});
        exp_q.push_back(st);
        i_core_exec_model.op(5'h03, 0, 1, 0, 0, 0, 0, 0, 0, 0);
        for (int i = 0; i < 30; i++) begin
            a = ($random(seed) & 1) ? 5'h03 : 5'($random(seed));
            {w, d, u, s} = 15'($random(seed));
            c = w && a == 5'h03 && ($random(seed) & 3) == 0;
            e = 4'($random(seed) & $random(seed));
            i_core_exec_model.op(a, w, 0, c, d, u, s, e, 0, 0);
            st = nxt(st, w && a == 5'h03, c, d, u, s, e);
            exp_q.push_back(st);
            i_core_exec_model.op(5'h03, 0, 1, 0, 0, 0, 0, 0, 0, 0);
            chk("status flags", {4'h0, st}, {4'h0, flg});
            chk("page select", {10'h0, st[6:5]}, {10'h0, pg});
        end
        i_core_exec_model.op(5'h05, 0, 1, 0, 0, 0, 0, 0, 0, 0);
        i_core_exec_model.op(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        chk("unmapped read", 12'h000, {3'h0, rdh, rdd});
        for (int n = 0; n < 8; n++) begin
            k = {4'($random(seed)), n[0] ^ n[2], 3'(n)};
            i_core_exec_model.op(0, 0, 0, 0, 0, 0, 0, 0, 1, k);
            i_core_exec_model.op(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
            chk("option setup", {6'h0, k[5:0]}, {4'h0, setup});
            chk("option fields", {6'h0, k[5:0]}, {6'h0, src, edg, asg, rate});
            chk("dividers", {4'h0, 4'(n + 1), k[3] ? 4'(n) : 4'h0}, {4'h0, tdiv, wdiv});
        end
        for (int o = 0; o < 4; o++) begin
            cfg = {9'($random(seed)), 1'(o >> 1), 2'(o)};
            if (o == 3) cfg[11:3] = 9'h1ff;
            repeat (3) @(posedge clk_sys_in);
            #1 chk("config", {8'h0, ~&cfg[11:3], cfg[2:0]}, {8'h0, prot, wen, osc});
        end
        reset_in = 1'b1;
        @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        chk("option rereset", 12'h03f, {4'h0, setup});
        exp_q.push_back(STATUS_RESET);
        i_core_exec_model.op(5'h03, 0, 1, 0, 0, 0, 0, 0, 0, 0);
        i_core_exec_model.op(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (2) @(posedge clk_sys_in);
        chk("pending reads", 12'h000, 12'(exp_q.size()));
        results();
    end
endmodule // tb
bind core_status_option_config status_props i_status_props (.*);
`default_nettype wire
